//--- efjc_pkg.sv
`default_nettype none
package efjc_pkg;
	// Command codes from the engine controller
	localparam logic [1:0] CMD_NOP    = 2'h0;
	localparam logic [1:0] CMD_PICKUP = 2'h1;
	localparam logic [1:0] CMD_STOP   = 2'h2;
	localparam logic [1:0] CMD_CLEAR  = 2'h3;
	// Status word bit positions
	localparam int ST_MOTOR    = 0;
	localparam int ST_BUSY     = 1;
	localparam int ST_PRESENT  = 2;
	localparam int ST_MULTI    = 3;
	localparam int ST_JAM      = 4;
	localparam int ST_JAM_DLY  = 5;
	localparam int ST_JAM_MULT = 6;
	localparam int ST_JAM_PRES = 7;
	localparam int ST_W        = 8;
	// Status value after reset
	localparam logic [7:0] ST_RESET = 8'h00;
	// Default intervals in cycles at 25 MHz
	localparam int CLK_MHZ        = 25;
	localparam int PICK_DELAY_US  = 100;
	localparam int PICK_DELAY_CYC = PICK_DELAY_US * CLK_MHZ;
	localparam int CHECK_US       = 40;
	localparam int CHECK_CYC      = CHECK_US * CLK_MHZ;
	localparam int CNT_W          = 16;
	// Sequencer states
	typedef enum logic [1:0] {
		EFJC_IDLE = 2'b00,
		EFJC_PICK = 2'b01,
		EFJC_FEED = 2'b10,
		EFJC_JAM  = 2'b11
	} efjc_state_e;
endpackage
`default_nettype wire

//--- efjc_timer.sv
`timescale 1ns/10ps
`default_nettype none
// Down counter raising done once the loaded interval expires
module efjc_timer (
	// Clock and reset
	input  wire logic                          clock,
	input  wire logic                          nrst,
	// Control
	input  wire logic                          start,
	input  wire logic                          run,
	input  wire logic [efjc_pkg::CNT_W-1:0]    load,
	// Result
	output var  logic                          done
);
	logic [efjc_pkg::CNT_W-1:0] cnt_reg;

	// Load on start, count while run
	always_ff @(posedge clock) begin
		if (!nrst) begin
			cnt_reg <= '0;
		end else if (start) begin
			cnt_reg <= load;
		end else if (run && cnt_reg != '0) begin
			cnt_reg <= cnt_reg - 16'h0001;
		end
	end

	assign done = run && !start && (cnt_reg == 16'h0001);
endmodule
`default_nettype wire

//--- efjc_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Pickup command turns on pickup motor
// - Act on each command, return status
// - Flag not blocking sensor means multifeed
// - Multifeed reported as pickup jam
// - Envelope present at check time: jam
// - Jam halts printing and notifies controller
// - No top-of-page edge in time: delay jam
// - Multifeed during pickup or feed: jam
module efjc_ctrl #(
	parameter logic [15:0] PICK_DELAY = 16'(efjc_pkg::PICK_DELAY_CYC),
	parameter logic [15:0] CHECK_TIME = 16'(efjc_pkg::CHECK_CYC)
) (
	// Clock and reset
	input  wire logic                      clock,
	input  wire logic                      nrst,
	// Command link from engine controller
	input  wire logic                      cmd_valid,
	input  wire logic [1:0]                cmd_code,
	output var  logic [efjc_pkg::ST_W-1:0] status,
	output var  logic                      jam_notify,
	output var  logic                      print_halt,
	// Feeder hardware
	input  wire logic                      envelope_presence_sensor,
	input  wire logic                      multifeed_flag_sensor,
	input  wire logic                      top_of_page_sensor,
	output var  logic                      envelope_pickup_motor
);
	efjc_pkg::efjc_state_e state_reg, state_next;
	logic tops_reg;
	logic dly_done, chk_done;
	logic jam_dly_reg, jam_mult_reg, jam_pres_reg;
	logic multi;
	logic tops_rise;
	logic is_pick, is_stop, is_clear;

	// Command decode
	function automatic logic cmd_is(input logic v, input logic [1:0] c, input logic [1:0] k);
		cmd_is = v && (c == k);
	endfunction

	assign is_pick  = cmd_is(cmd_valid, cmd_code, efjc_pkg::CMD_PICKUP);
	assign is_stop  = cmd_is(cmd_valid, cmd_code, efjc_pkg::CMD_STOP);
	assign is_clear = cmd_is(cmd_valid, cmd_code, efjc_pkg::CMD_CLEAR);
	assign multi     = !multifeed_flag_sensor;
	assign tops_rise = top_of_page_sensor && !tops_reg;

	// Top-of-page edge history
	always_ff @(posedge clock) begin
		if (!nrst) begin
			tops_reg <= 1'b0;
		end else begin
			tops_reg <= top_of_page_sensor;
		end
	end

	// Pickup delay interval from pickup start
	efjc_timer u_dly (
		.clock (clock),
		.nrst  (nrst),
		.start (state_reg == efjc_pkg::EFJC_IDLE && is_pick),
		.run   (state_reg == efjc_pkg::EFJC_PICK),
		.load  (PICK_DELAY),
		.done  (dly_done)
	);

	// Presence check time after leading edge
	efjc_timer u_chk (
		.clock (clock),
		.nrst  (nrst),
		.start (state_reg == efjc_pkg::EFJC_PICK && tops_rise),
		.run   (state_reg == efjc_pkg::EFJC_FEED),
		.load  (CHECK_TIME),
		.done  (chk_done)
	);

	// Next-state logic
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			efjc_pkg::EFJC_IDLE: begin
				if (is_pick) begin
					state_next = efjc_pkg::EFJC_PICK;
				end
			end
			efjc_pkg::EFJC_PICK: begin
				if (multi || dly_done) begin
					state_next = efjc_pkg::EFJC_JAM;
				end else if (is_stop) begin
					state_next = efjc_pkg::EFJC_IDLE;
				end else if (tops_rise) begin
					state_next = efjc_pkg::EFJC_FEED;
				end
			end
			efjc_pkg::EFJC_FEED: begin
				if (multi || (chk_done && envelope_presence_sensor)) begin
					state_next = efjc_pkg::EFJC_JAM;
				end else if (is_stop || chk_done) begin
					state_next = efjc_pkg::EFJC_IDLE;
				end
			end
			efjc_pkg::EFJC_JAM: begin
				if (is_clear) begin
					state_next = efjc_pkg::EFJC_IDLE;
				end
			end
		endcase
	end

	// State register
	always_ff @(posedge clock) begin
		if (!nrst) begin
			state_reg <= efjc_pkg::EFJC_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Jam cause flags, set wins over clear
	always_ff @(posedge clock) begin
		if (!nrst) begin
			jam_dly_reg  <= 1'b0;
			jam_mult_reg <= 1'b0;
			jam_pres_reg <= 1'b0;
		end else begin
			jam_dly_reg <= (state_reg == efjc_pkg::EFJC_PICK && dly_done && !multi)
				|| (jam_dly_reg && !is_clear);
			jam_mult_reg <= ((state_reg == efjc_pkg::EFJC_PICK
				|| state_reg == efjc_pkg::EFJC_FEED) && multi)
				|| (jam_mult_reg && !is_clear);
			jam_pres_reg <= (state_reg == efjc_pkg::EFJC_FEED && chk_done
				&& envelope_presence_sensor && !multi)
				|| (jam_pres_reg && !is_clear);
		end
	end

	// Outputs registered; motor, halt, notify, busy and jam bit from next state, jam cause bits from the cause flag registers
	always_ff @(posedge clock) begin
		if (!nrst) begin
			envelope_pickup_motor <= 1'b0;
			print_halt            <= 1'b0;
			jam_notify            <= 1'b0;
			status                <= efjc_pkg::ST_RESET;
		end else begin
			envelope_pickup_motor <= (state_next == efjc_pkg::EFJC_PICK)
				|| (state_next == efjc_pkg::EFJC_FEED);
			print_halt <= (state_next == efjc_pkg::EFJC_JAM);
			jam_notify <= (state_next == efjc_pkg::EFJC_JAM)
				&& (state_reg != efjc_pkg::EFJC_JAM);
			status[efjc_pkg::ST_MOTOR]    <= (state_next == efjc_pkg::EFJC_PICK)
				|| (state_next == efjc_pkg::EFJC_FEED);
			status[efjc_pkg::ST_BUSY]     <= (state_next != efjc_pkg::EFJC_IDLE);
			status[efjc_pkg::ST_PRESENT]  <= envelope_presence_sensor;
			status[efjc_pkg::ST_MULTI]    <= multi;
			status[efjc_pkg::ST_JAM]      <= (state_next == efjc_pkg::EFJC_JAM);
			status[efjc_pkg::ST_JAM_DLY]  <= jam_dly_reg;
			status[efjc_pkg::ST_JAM_MULT] <= jam_mult_reg;
			status[efjc_pkg::ST_JAM_PRES] <= jam_pres_reg;
		end
	end

	// Checks
	property p_pick_motor;
		@(posedge clock) disable iff (!nrst)
		(state_reg == efjc_pkg::EFJC_IDLE && is_pick) |=> envelope_pickup_motor;
	endproperty
	a_pick_motor: assert property (p_pick_motor) else $error("motor not on after pickup");

	property p_status_busy;
		@(posedge clock) disable iff (!nrst)
		1'b1 |=> status[efjc_pkg::ST_BUSY] == (state_reg != efjc_pkg::EFJC_IDLE);
	endproperty
	a_status_busy: assert property (p_status_busy) else $error("busy status wrong");

	property p_multi_flag;
		@(posedge clock) disable iff (!nrst)
		1'b1 |=> status[efjc_pkg::ST_MULTI] == !$past(multifeed_flag_sensor);
	endproperty
	a_multi_flag: assert property (p_multi_flag) else $error("multifeed sense wrong");

	property p_multi_jam;
		@(posedge clock) disable iff (!nrst)
		(state_reg == efjc_pkg::EFJC_PICK && !multifeed_flag_sensor)
		|=> state_reg == efjc_pkg::EFJC_JAM ##1 status[efjc_pkg::ST_JAM_MULT];
	endproperty
	a_multi_jam: assert property (p_multi_jam) else $error("multifeed not a jam");

	property p_pres_jam;
		@(posedge clock) disable iff (!nrst)
		(state_reg == efjc_pkg::EFJC_FEED && chk_done && envelope_presence_sensor)
		|=> state_reg == efjc_pkg::EFJC_JAM;
	endproperty
	a_pres_jam: assert property (p_pres_jam) else $error("presence jam missed");

	property p_halt;
		@(posedge clock) disable iff (!nrst)
		$rose(print_halt) |-> jam_notify && !envelope_pickup_motor;
	endproperty
	a_halt: assert property (p_halt) else $error("halt without notify");

	property p_delay_jam;
		@(posedge clock) disable iff (!nrst)
		(state_reg == efjc_pkg::EFJC_IDLE && is_pick && !top_of_page_sensor)
		##1 (!top_of_page_sensor && multifeed_flag_sensor && !is_stop)[*8]
		|-> state_reg == efjc_pkg::EFJC_PICK || PICK_DELAY < 16'h0009;
	endproperty
	a_delay_jam: assert property (p_delay_jam) else $error("early delay jam");

	property p_feed_multi;
		@(posedge clock) disable iff (!nrst)
		(state_reg == efjc_pkg::EFJC_FEED && !multifeed_flag_sensor) |=> print_halt;
	endproperty
	a_feed_multi: assert property (p_feed_multi) else $error("feed multifeed missed");

	c_pick: cover property (@(posedge clock) disable iff (!nrst)
		state_reg == efjc_pkg::EFJC_PICK ##1 state_reg == efjc_pkg::EFJC_FEED);
	c_done: cover property (@(posedge clock) disable iff (!nrst)
		state_reg == efjc_pkg::EFJC_FEED ##1 state_reg == efjc_pkg::EFJC_IDLE);
	c_dly: cover property (@(posedge clock) disable iff (!nrst) $rose(jam_dly_reg));
	c_clear: cover property (@(posedge clock) disable iff (!nrst)
		state_reg == efjc_pkg::EFJC_JAM ##1 state_reg == efjc_pkg::EFJC_IDLE);
endmodule
`default_nettype wire

//--- efjc_engine.sv
`timescale 1ns/10ps
`default_nettype none
// Engine controller side of the command link
module efjc_engine (
	// Clock
	input  wire logic       clock,
	// Command link
	output var  logic       cmd_valid,
	output var  logic [1:0] cmd_code,
	input  wire logic       jam_notify
);
	int notify_cnt = 0;
	initial begin
		cmd_valid = 1'b0;
		cmd_code = 2'h0;
	end
	// One-cycle command strobe, code scrambled once released
	task automatic send(input logic [1:0] c);
		@(posedge clock) #1;
		cmd_valid = 1'b1;
		cmd_code = c;
		@(posedge clock) #1;
		cmd_valid = 1'b0;
		cmd_code = ~c;
	endtask
	// Counts jam notifications
	always @(posedge clock) if (jam_notify === 1'b1) notify_cnt++;
endmodule
`default_nettype wire

//--- envelope_feed_jam_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
module envelope_feed_jam_control_tb;
	logic clock = 1'b0, nrst = 1'b0, pres = 1'b0, flag = 1'b1, tpos = 1'b0;
	logic cmd_valid, jam_notify, print_halt, motor;
	logic [1:0] cmd_code;
	logic [7:0] status;
	int mismatches = 0, checked = 0, cycles = 0;
	// Clock, timeout
	always #20 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 2000) begin
			mismatches++;
			conclude();
		end
	end
	efjc_engine u_efjc_engine (.clock(clock), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.jam_notify(jam_notify));
	efjc_ctrl #(.PICK_DELAY(16'h0014), .CHECK_TIME(16'h000A)) u_efjc_ctrl (.clock(clock),
		.nrst(nrst), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .status(status),
		.jam_notify(jam_notify), .print_halt(print_halt), .envelope_presence_sensor(pres),
		.multifeed_flag_sensor(flag), .top_of_page_sensor(tpos), .envelope_pickup_motor(motor));
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic chk(input logic ok, input string m);
		checked++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task automatic cmd(input logic [1:0] c);
		u_efjc_engine.send(c);
	endtask
	// Halted with one cause bit, then cleared
	task automatic jam_seen(input int b, input string m);
		chk(print_halt === 1'b1 && status[efjc_pkg::ST_JAM] === 1'b1, m);
		chk(status[b] === 1'b1 && motor === 1'b0, m);
		cmd(efjc_pkg::CMD_PICKUP);
		chk(print_halt === 1'b1 && motor === 1'b0, "pickup refused in jam");
		cmd(efjc_pkg::CMD_CLEAR);
		cyc(2);
		chk(print_halt === 1'b0 && status[efjc_pkg::ST_JAM] === 1'b0, "clear");
	endtask
	// Normal feed, idle refusal, stop
	task automatic t_normal;
		cmd(efjc_pkg::CMD_CLEAR);
		cyc(2);
		chk(print_halt === 1'b0 && motor === 1'b0, "clear in idle");
		cmd(efjc_pkg::CMD_PICKUP);
		cyc(1);
		chk(motor === 1'b1 && status[efjc_pkg::ST_BUSY] === 1'b1, "motor on");
		chk(status[efjc_pkg::ST_MOTOR] === 1'b1, "motor status");
		tpos = 1'b1;
		cyc(14);
		chk(motor === 1'b0 && status[efjc_pkg::ST_BUSY] === 1'b0, "back idle");
		chk(status[efjc_pkg::ST_MOTOR] === 1'b0 && status[efjc_pkg::ST_PRESENT] === 1'b0,
			"idle status");
		chk(print_halt === 1'b0, "no jam");
		tpos = 1'b0;
		cmd(efjc_pkg::CMD_PICKUP);
		cyc(2);
		cmd(efjc_pkg::CMD_STOP);
		cyc(2);
		chk(motor === 1'b0 && print_halt === 1'b0, "stop");
		cmd(efjc_pkg::CMD_PICKUP);
		cyc(1);
		tpos = 1'b1;
		cmd(efjc_pkg::CMD_STOP);
		cyc(2);
		chk(motor === 1'b0 && status[efjc_pkg::ST_BUSY] === 1'b0, "stop in feed");
		tpos = 1'b0;
		$display("done normal");
	endtask
	// No top-of-page edge within the interval
	task automatic t_delay;
		cmd(efjc_pkg::CMD_PICKUP);
		cyc(10);
		chk(print_halt === 1'b0, "early delay jam");
		cyc(15);
		jam_seen(efjc_pkg::ST_JAM_DLY, "delay jam");
		chk(u_efjc_engine.notify_cnt == 1, "notify count");
		$display("done delay");
	endtask
	// Flag leaves the sensor during pickup, then during feed
	task automatic t_multi;
		cmd(efjc_pkg::CMD_PICKUP);
		cyc(3);
		flag = 1'b0;
		cyc(3);
		chk(status[efjc_pkg::ST_MULTI] === 1'b1, "multifeed bit");
		jam_seen(efjc_pkg::ST_JAM_MULT, "multifeed jam");
		flag = 1'b1;
		cmd(efjc_pkg::CMD_PICKUP);
		cyc(1);
		tpos = 1'b1;
		cyc(2);
		flag = 1'b0;
		cyc(3);
		jam_seen(efjc_pkg::ST_JAM_MULT, "feed multifeed jam");
		flag = 1'b1;
		tpos = 1'b0;
		chk(u_efjc_engine.notify_cnt == 3, "notify count multi");
		$display("done multi");
	endtask
	// Envelope still present at check time
	task automatic t_presence;
		pres = 1'b1;
		cmd(efjc_pkg::CMD_PICKUP);
		cyc(2);
		tpos = 1'b1;
		cyc(6);
		chk(print_halt === 1'b0, "early check");
		chk(status[efjc_pkg::ST_PRESENT] === 1'b1, "presence status");
		cyc(8);
		jam_seen(efjc_pkg::ST_JAM_PRES, "presence jam");
		pres = 1'b0;
		tpos = 1'b0;
		chk(u_efjc_engine.notify_cnt == 4, "notify count presence");
		$display("done presence");
	endtask
	task automatic conclude;
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Reset, then scenarios
	initial begin
		cyc(2);
		nrst = 1'b1;
		chk(status === efjc_pkg::ST_RESET && motor === 1'b0, "reset");
		t_normal();
		t_delay();
		t_multi();
		t_presence();
		conclude();
	end
endmodule
`default_nettype wire
